/* verif/pcs_checker.sv */
// port assertions of the port-clock control block
module pcs_checker (
	// clock, reset and bus
	input wire logic                    mclk_in,
	input wire logic                    rst_in,
	input wire logic                    avs_read_in,
	input wire logic                    avs_write_in,
	input wire logic [31:0]             avs_readdata_out,
	input wire logic                    avs_waitrequest_out,
	// port side
	input wire pcs_pkg::pcs_src_t [7:0] port_src_in,
	input wire logic [2:0][4:0]         gen_clk_in,
	input wire logic [3:0]              out_slot_active_in,
	input wire logic [3:0]              out_data_in,
	input wire logic [3:0]              serial_output_pin_out,
	input wire logic [3:0]              serial_output_pin_oe_out,
	input wire logic [7:0]              port_clk_out,
	input wire logic [7:0]              port_clk_oe_out,
	input wire logic [7:0]              port_master_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	logic [7:0] mvec;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			mvec[i] = port_src_in[i] == 6'h24;
	end
	a_write_no_wait: assert property (avs_write_in |-> !avs_waitrequest_out)
		else $error("write stalled");
	a_read_one_wait: assert property ($rose(avs_read_in) |->
		avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("read wait not one cycle");
	a_read_data_hold: assert property (!(avs_read_in && avs_waitrequest_out) |->
		##1 $stable(avs_readdata_out))
		else $error("read data moved");
	a_clock_pin_drive: assert property (!$past(rst_in) |->
		port_clk_oe_out == $past(mvec))
		else $error("clock enable not from sources");
	a_master_follow: assert property (!$past(rst_in) |->
		port_master_out == $past(mvec))
		else $error("master flag wrong");
	a_slave_clk_low: assert property ((port_clk_out & ~port_master_out) == 8'h00)
		else $error("slave port drives clock");
	a_gen_quiet: assert property (gen_clk_in == '0 |=> port_clk_out == 8'h00)
		else $error("clock without source");
	a_slot_driven: assert property (!$past(rst_in) |->
		($past(out_slot_active_in) & ~serial_output_pin_oe_out) == 4'h0)
		else $error("active slot not driven");
	a_slot_data: assert property (!$past(rst_in) |->
		serial_output_pin_out == ($past(out_slot_active_in) & $past(out_data_in)))
		else $error("pin data wrong");
endmodule

bind pcs_top pcs_checker i_chk (.*);

/* verif/tb_pcs_top.sv */
// self-checking bench of the port-clock control block
module tb_pcs_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    mclk_in = 1'b0;
	logic                    rst_in = 1'b1;
	logic [17:0]             avs_address_in = 18'h00000;
	logic                    avs_read_in = 1'b0;
	logic                    avs_write_in = 1'b0;
	logic [3:0]              avs_byteenable_in = 4'h3;
	logic [31:0]             avs_writedata_in = 32'h00000000;
	logic [31:0]             avs_readdata_out;
	logic                    avs_waitrequest_out;
	pcs_pkg::pcs_src_t [7:0] port_src_in = '0;
	logic [2:0][4:0]         gen_clk_in = '0;
	logic [3:0]              out_slot_active_in = 4'h0;
	logic [3:0]              out_data_in = 4'h0;
	logic [3:0]              serial_output_pin_out;
	logic [3:0]              serial_output_pin_oe_out;
	logic [7:0]              port_clk_out;
	logic [7:0]              port_clk_oe_out;
	logic [7:0]              port_master_out;
	int                      fails = 0;
	int                      check_count = 0;
	logic [31:0]             q;
	pcs_top i_dut (.*);
	initial
	begin
		forever #2 mclk_in = ~mclk_in;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one bus transfer; the request stands until waitrequest is seen low
	// index -1 is an unmapped word, -2 the status word
	task automatic bus(input logic wr, input int i, input logic [15:0] d);
		@(posedge mclk_in);
		avs_address_in <= (i == -2) ? 18'h3c900 :
			(i < 0) ? 18'h3c808 : 18'h3c804 + 18'(i * 16);
		avs_writedata_in <= {16'h0000, d};
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		do
			@(posedge mclk_in);
		while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	// drive port inputs, then look once the registered outputs have landed
	task automatic drive(input logic [14:0] g, input logic [3:0] s, input logic [3:0] d);
		@(posedge mclk_in);
		gen_clk_in <= g;
		out_slot_active_in <= s;
		out_data_in <= d;
		@(posedge mclk_in);
		@(negedge mclk_in);
	endtask
	task automatic s_regs();
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b0, i, 16'h0000);
			cmp(q, 32'h00000002);
		end
		for (int i = 0; i < 8; i++)
			bus(1'b1, i, 16'(((i % 3) << 3) | (i % 5) | ((i & 1) << 5)));
		bus(1'b1, -1, 16'h001b);
		for (int i = -1; i < 8; i++)
		begin
			bus(1'b0, i, 16'h0000);
			cmp(q, (i < 0) ? 32'h0 : 32'(((i % 3) << 3) | (i % 5) | ((i & 1) << 5)));
		end
		// upper lane masked off: only the low byte may land
		avs_byteenable_in <= 4'h1;
		bus(1'b1, 0, 16'h5a24);
		avs_byteenable_in <= 4'h3;
		bus(1'b0, 0, 16'h0000);
		cmp(q, 32'h00000024);
	endtask
	task automatic s_select();
		port_src_in[4] <= 6'h24;
		for (int g = 0; g < 3; g++)
			for (int r = 0; r < 5; r++)
			begin
				bus(1'b1, 4, 16'((g << 3) | r));
				drive(15'(1) << (g * 5 + r), 4'h0, 4'h0);
				cmp({port_clk_out[4], port_clk_oe_out[4]}, 2'b11);
				drive(~(15'(1) << (g * 5 + r)), 4'h0, 4'h0);
				cmp(port_clk_out[4], 1'b0);
			end
		// status: master flag of port 4, generator 3 in use there
		bus(1'b0, -2, 16'h0000);
		cmp(q, 32'h00020010);
		port_src_in[4] <= 6'h20;
		drive('1, 4'h0, 4'h0);
		cmp({port_clk_out[4], port_clk_oe_out[4]}, 2'b00);
	endtask
	task automatic s_float();
		bus(1'b1, 5, 16'h0022);
		drive('0, 4'h0, 4'h2);
		cmp({serial_output_pin_oe_out[1], serial_output_pin_out[1]}, 2'b00);
		drive('0, 4'h2, 4'h2);
		cmp({serial_output_pin_oe_out[1], serial_output_pin_out[1]}, 2'b11);
		bus(1'b1, 5, 16'h0002);
		drive('0, 4'h0, 4'h2);
		cmp({serial_output_pin_oe_out[1], serial_output_pin_out[1]}, 2'b10);
		// float on an input port must leave its clock behaviour alone
		bus(1'b1, 0, 16'h0022);
		port_src_in[0] <= 6'h24;
		drive(15'h0004, 4'h0, 4'h0);
		cmp({port_clk_out[0], port_clk_oe_out[0]}, 2'b11);
	endtask
	initial
	begin
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		s_regs();
		s_select();
		s_float();
		conclude();
	end
	initial
	begin
		#20000;
		fails++;
		conclude();
	end
endmodule

/* verilog/pcs_defs.svh */
// offsets, field positions, reset values and codes of the port-clock control block
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define PCS_IDX_INPUT0      16'hf201
`define PCS_IDX_INPUT1      16'hf205
`define PCS_IDX_INPUT2      16'hf209
`define PCS_IDX_INPUT3      16'hf20d
`define PCS_IDX_OUTPUT0     16'hf211
`define PCS_IDX_OUTPUT1     16'hf215
`define PCS_IDX_OUTPUT2     16'hf219
`define PCS_IDX_OUTPUT3     16'hf21d
`define PCS_IDX_STRIDE      16'h0004
`define PCS_IDX_STATUS      16'hf240

// field positions inside a port-clock control register
`define PCS_FLOAT_BIT       5
`define PCS_GEN_HI          4
`define PCS_GEN_LO          3
`define PCS_RATE_HI         2
`define PCS_RATE_LO         0

// reset value and codes
`define PCS_CTRL_RESET      16'h0002
`define PCS_MASTER_CODE     3'h4
`define PCS_GEN_CODE_MAX    2'h2
`define PCS_RATE_CODE_MAX   3'h4

`endif

/* verilog/pcs_pkg.sv */
// types shared by the port-clock control block
package pcs_pkg;

	typedef struct packed {
		logic [9:0] reserved;
		logic       out_float;
		logic [1:0] clock_generator_pick;
		logic [2:0] rate_multiple_sel;
	} pcs_ctrl_t;

	// companion register fields of one port, from the frame-format block
	typedef struct packed {
		logic [2:0] frame_clock_source;
		logic [2:0] bit_clock_source;
	} pcs_src_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [17:0] address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} pcs_avs_req_t;

	typedef struct packed {
		logic       port_clk;
		logic       port_clk_oe;
		logic       master;
		logic [1:0] gen_used;
		logic       pin_data;
		logic       pin_oe;
	} pcs_port_state_t;

	typedef enum logic [1:0] {
		PCS_BUS_IDLE,
		PCS_BUS_READ_DONE
	} pcs_bus_state_t;

	typedef struct packed {
		pcs_ctrl_t [7:0] regs;
		logic [31:0]     rdata;
		pcs_bus_state_t  bus;
	} pcs_top_state_t;

endpackage

/* verilog/pcs_port_ctrl.sv */
// per-port clock selection and data pin drive for one serial port
`include "pcs_defs.svh"

module pcs_port_ctrl #(
	parameter bit IS_OUTPUT = 1'b0
) (
	// clock and reset
	input  wire logic                   mclk_in,
	input  wire logic                   rst_in,
	// configuration
	input  wire pcs_pkg::pcs_ctrl_t     ctrl_in,
	input  wire pcs_pkg::pcs_src_t      src_in,
	// generator rate outputs, [generator][rate]
	input  wire logic [2:0][4:0]        gen_clk_in,
	// serial data for output ports
	input  wire logic                   slot_active_in,
	input  wire logic                   data_in,
	// results
	output pcs_pkg::pcs_port_state_t    state_out
);

	pcs_pkg::pcs_port_state_t s_q;
	pcs_pkg::pcs_port_state_t s_d;

	always_comb
	begin
		logic       master;
		logic       legal;
		logic [4:0] row;
		master = 1'b0;
		legal  = 1'b0;
		row    = 5'h00;
		s_d    = s_q;
		// only a full clock master uses the pick and rate fields
		master = (src_in.frame_clock_source == `PCS_MASTER_CODE) &&
			(src_in.bit_clock_source == `PCS_MASTER_CODE);
		// reserved codes yield a quiet clock rather than an alias
		legal = (ctrl_in.clock_generator_pick <= `PCS_GEN_CODE_MAX) &&
			(ctrl_in.rate_multiple_sel <= `PCS_RATE_CODE_MAX);
		if (legal)
		begin
			row = gen_clk_in[ctrl_in.clock_generator_pick];
		end
		s_d.master      = master;
		s_d.gen_used    = master ? ctrl_in.clock_generator_pick : 2'h0;
		s_d.port_clk    = master && legal && row[ctrl_in.rate_multiple_sel];
		s_d.port_clk_oe = master;
		if (IS_OUTPUT)
		begin
			s_d.pin_data = slot_active_in ? data_in : 1'b0;
			s_d.pin_oe   = ctrl_in.out_float ? slot_active_in : 1'b1;
		end
		else
		begin
			// input ports never drive their data pin; float bit is not looked at
			s_d.pin_data = 1'b0;
			s_d.pin_oe   = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign state_out = s_q;

endmodule

/* verilog/pcs_top.sv */
// port-clock control register bank for four serial input and four serial output ports
//
// Operation
// - Eight control registers, stride four; first four inputs 0-3, last four outputs 0-3.
// - Float bit one floats output pin in unused slots; zero drives every slot.
// - Float bit has no effect on serial input ports.
// - Generator field: 00 generator 1, 01 generator 2, 10 high precision generator 3.
// - Generator and rate used only when frame and bit sources are both master.
// - Rate field: 000 quarter, 001 half, 010 base, 011 double, 100 quadruple.
// - Every control register resets to 0x0002: base rate, generator 1, all driven.
// - Source code 100 makes the port master; it drives its clock pin.
`include "pcs_defs.svh"

module pcs_top (
	// clock and reset
	input  wire logic                    mclk_in,
	input  wire logic                    rst_in,
	// avalon-mm slave
	input  wire logic [17:0]             avs_address_in,
	input  wire logic                    avs_read_in,
	input  wire logic                    avs_write_in,
	input  wire logic [3:0]              avs_byteenable_in,
	input  wire logic [31:0]             avs_writedata_in,
	output logic [31:0]                  avs_readdata_out,
	output logic                         avs_waitrequest_out,
	// companion register fields, one per port, inputs first
	input  wire pcs_pkg::pcs_src_t [7:0] port_src_in,
	// clock generator outputs, [generator][rate]
	input  wire logic [2:0][4:0]         gen_clk_in,
	// serial output data path
	input  wire logic [3:0]              out_slot_active_in,
	input  wire logic [3:0]              out_data_in,
	output logic [3:0]                   serial_output_pin_out,
	output logic [3:0]                   serial_output_pin_oe_out,
	// port clocks, inputs 0-3 then outputs 0-3
	output logic [7:0]                   port_clk_out,
	output logic [7:0]                   port_clk_oe_out,
	output logic [7:0]                   port_master_out
);

	localparam int NPORTS = 8;
	localparam int NOUT   = 4;

	pcs_pkg::pcs_top_state_t          s_q;
	pcs_pkg::pcs_top_state_t          s_d;
	pcs_pkg::pcs_avs_req_t            req;
	pcs_pkg::pcs_port_state_t [7:0]   port_st;
	logic [15:0]                      word_idx;
	logic [7:0]                       hit;
	logic                             hit_status;
	logic [15:0]                      lane_mask;
	logic [31:0]                      status_word;

	assign req.read       = avs_read_in;
	assign req.write      = avs_write_in;
	assign req.address    = avs_address_in;
	assign req.byteenable = avs_byteenable_in;
	assign req.writedata  = avs_writedata_in;

	// printed offsets are word indices; byte address bits [1:0] are ignored
	assign word_idx   = req.address[17:2];
	assign hit_status = (word_idx == `PCS_IDX_STATUS);
	assign lane_mask  = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};

	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi++)
		begin : g_dec
			assign hit[gi] = (word_idx ==
				16'(`PCS_IDX_INPUT0 + gi * `PCS_IDX_STRIDE));
		end
	endgenerate

	// status: [7:0] master flags, [23:8] generator in use per port, two bits each
	always_comb
	begin
		status_word = 32'h0000_0000;
		for (int i = 0; i < NPORTS; i++)
		begin
			status_word[i]             = port_st[i].master;
			status_word[8 + 2 * i +: 2] = port_st[i].gen_used;
		end
	end

	always_comb
	begin
		logic [15:0] cur;
		cur = 16'h0000;
		s_d = s_q;
		case (s_q.bus)
			pcs_pkg::PCS_BUS_IDLE:
			begin
				if (req.write)
				begin
					for (int i = 0; i < NPORTS; i++)
					begin
						if (hit[i])
						begin
							cur = s_q.regs[i];
							// reserved bits are kept as written
							s_d.regs[i] = (cur & ~lane_mask) |
								(req.writedata[15:0] & lane_mask);
						end
					end
				end
				else if (req.read)
				begin
					s_d.rdata = 32'h0000_0000;
					for (int i = 0; i < NPORTS; i++)
					begin
						if (hit[i])
						begin
							s_d.rdata = {16'h0000, s_q.regs[i]};
						end
					end
					if (hit_status)
					begin
						s_d.rdata = status_word;
					end
					s_d.bus = pcs_pkg::PCS_BUS_READ_DONE;
				end
			end
			pcs_pkg::PCS_BUS_READ_DONE:
			begin
				// one answered cycle; the master drops read on this edge
				s_d.bus = pcs_pkg::PCS_BUS_IDLE;
			end
			default:
			begin
				s_d.bus = pcs_pkg::PCS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < NPORTS; i++)
			begin
				s_q.regs[i] <= `PCS_CTRL_RESET;
			end
			s_q.rdata <= 32'h0000_0000;
			s_q.bus   <= pcs_pkg::PCS_BUS_IDLE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// writes complete at once; reads wait one cycle so data come from a register
	assign avs_waitrequest_out = req.read && (s_q.bus == pcs_pkg::PCS_BUS_IDLE);
	assign avs_readdata_out    = s_q.rdata;

	generate
		for (gi = 0; gi < NPORTS; gi++)
		begin : g_port
			if (gi < NOUT)
			begin : g_in
				pcs_port_ctrl #(
					.IS_OUTPUT (1'b0)
				) u_port (
					.mclk_in        (mclk_in),
					.rst_in         (rst_in),
					.ctrl_in        (s_q.regs[gi]),
					.src_in         (port_src_in[gi]),
					.gen_clk_in     (gen_clk_in),
					.slot_active_in (1'b0),
					.data_in        (1'b0),
					.state_out      (port_st[gi])
				);
			end
			else
			begin : g_out
				pcs_port_ctrl #(
					.IS_OUTPUT (1'b1)
				) u_port (
					.mclk_in        (mclk_in),
					.rst_in         (rst_in),
					.ctrl_in        (s_q.regs[gi]),
					.src_in         (port_src_in[gi]),
					.gen_clk_in     (gen_clk_in),
					.slot_active_in (out_slot_active_in[gi - NOUT]),
					.data_in        (out_data_in[gi - NOUT]),
					.state_out      (port_st[gi])
				);
				assign serial_output_pin_out[gi - NOUT]    = port_st[gi].pin_data;
				assign serial_output_pin_oe_out[gi - NOUT] = port_st[gi].pin_oe;
			end
			assign port_clk_out[gi]    = port_st[gi].port_clk;
			assign port_clk_oe_out[gi] = port_st[gi].port_clk_oe;
			assign port_master_out[gi] = port_st[gi].master;
		end
	endgenerate

endmodule
